// ==== pkg/ppdp_regs.svh ====
// register map, field positions and timing counts of the print data port
// Behaviour
// - eight data lines, bit one to eight, high means one
// - after a byte, acknowledge output goes low for about five microseconds
// - busy stays high whenever the port cannot take data
// - paper-out output goes high when the paper has run out
// - selected output shows the printer is in the selected state
// - auto line feed low, or forced by switch, requests a line feed
// - initialise low over fifty microseconds resets port, clears buffer
// - data taken only while host select is low or forced low
`ifndef PPDP_REGS_SVH
`define PPDP_REGS_SVH

// ***********************************************
// bus and register offsets
// ***********************************************
`define PPDP_ADDR_W 8
`define PPDP_CTRL_OFS 8'h00
`define PPDP_STATUS_OFS 8'h04
`define PPDP_DATA_OFS 8'h08
`define PPDP_IRQ_STAT_OFS 8'h0c
`define PPDP_IRQ_EN_OFS 8'h10
`define PPDP_IRQ_CLR_OFS 8'h14
`define PPDP_RESP_OKAY 2'h0
`define PPDP_RESP_SLVERR 2'h2

// ***********************************************
// control fields and reset value
// ***********************************************
`define PPDP_CTRL_W 6
`define PPDP_CTRL_ONLINE 0
`define PPDP_CTRL_PAPER_OUT 1
`define PPDP_CTRL_FAULT 2
`define PPDP_CTRL_PRINTING 3
`define PPDP_CTRL_SEL_FORCE 4
`define PPDP_CTRL_ALF_FORCE 5
`define PPDP_CTRL_RST 6'h10

// ***********************************************
// interrupt events
// ***********************************************
`define PPDP_IRQ_W 2
`define PPDP_IRQ_BYTE 0
`define PPDP_IRQ_INIT 1

// ***********************************************
// timing
// ***********************************************
`define PPDP_CLK_MHZ 20
`define PPDP_ACK_NS 5000
`define PPDP_INIT_NS 50000
`define PPDP_ACK_CYC ((`PPDP_ACK_NS * `PPDP_CLK_MHZ) / 1000)
`define PPDP_INIT_CYC ((`PPDP_INIT_NS * `PPDP_CLK_MHZ + 999) / 1000)
`define PPDP_TMR_W 12

`endif

// ==== pkg/ppdp_pkg.sv ====
// types shared by the print data port modules
package ppdp_pkg;

  // ***********************************************
  // host pins
  // ***********************************************
  typedef struct packed {
    logic strobe_n;
    logic [7:0] data;
    logic auto_line_feed_n;
    logic host_select_n;
    logic init_n;
  } ppdp_host_in_t;

  typedef struct packed {
    logic byte_accepted_pulse_n;
    logic busy;
    logic paper_out;
    logic printer_selected;
    logic error_n;
  } ppdp_host_out_t;

  // ***********************************************
  // register access from the bus slave
  // ***********************************************
  typedef struct packed {
    logic wr;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic rd;
    logic [7:0] raddr;
  } ppdp_reg_req_t;

  typedef enum logic [1:0] {
    PPDP_IDLE,
    PPDP_TAKE,
    PPDP_HOLD,
    PPDP_ACK
  } ppdp_state_t;

endpackage

// ==== logic/ppdp_timer.sv ====
// saturating cycle counter: done once run has been high limit cycles
`timescale 1ns/1ps
module ppdp_timer #(
  parameter int W = 12,
  parameter logic [W-1:0] LIMIT = 12'h063
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic clear, // restart from zero
  input wire logic run, // count this cycle
  output logic done // limit reached
);

  logic [W-1:0] cnt;

  // count up to the limit and stay there
  assign done = (cnt == LIMIT);

  // counter
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      cnt <= '0;
    end else if (run && !done) begin
      cnt <= cnt + 1'b1;
    end
  end

endmodule

// ==== logic/ppdp_axil_slave.sv ====
// axi4-lite slave front end: takes requests, registers the answers
`timescale 1ns/1ps
`include "ppdp_regs.svh"
module ppdp_axil_slave (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output ppdp_pkg::ppdp_reg_req_t req, // access to the register file
  input wire logic [31:0] rd_data, // data at raddr
  input wire logic rd_err, // raddr unmapped
  input wire logic wr_err // waddr not a writable register
);

  logic wr_take;
  logic rd_take;

  // address and data of a write are taken together, one at a time
  assign wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign rd_take = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;
  assign s_axi_arready = rd_take;
  assign req.wr = wr_take;
  assign req.waddr = s_axi_awaddr;
  assign req.wdata = s_axi_wdata;
  assign req.wstrb = s_axi_wstrb;
  assign req.rd = rd_take;
  assign req.raddr = s_axi_araddr;

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PPDP_RESP_OKAY;
    end else if (wr_take) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_err ? `PPDP_RESP_SLVERR : `PPDP_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `PPDP_RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_err ? `PPDP_RESP_SLVERR : `PPDP_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ==== logic/ppdp_port.sv ====
// parallel print data port: host handshake, register file and interrupt
`timescale 1ns/1ps
`include "ppdp_regs.svh"
module ppdp_port (
  input wire logic aclk, // system clock, 20 MHz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire ppdp_pkg::ppdp_host_in_t host_in, // pins from the host
  output ppdp_pkg::ppdp_host_out_t host_out, // pins to the host
  output logic irq // level interrupt
);

  // ***********************************************
  // declarations
  // ***********************************************
  localparam logic [`PPDP_TMR_W-1:0] ACK_LIM =
    `PPDP_TMR_W'(`PPDP_ACK_CYC - 1);
  localparam logic [`PPDP_TMR_W-1:0] INIT_LIM =
    `PPDP_TMR_W'(`PPDP_INIT_CYC - 1);

  ppdp_pkg::ppdp_reg_req_t req;
  ppdp_pkg::ppdp_state_t state;
  ppdp_pkg::ppdp_state_t next_state;
  logic [`PPDP_CTRL_W-1:0] ctrl;
  logic [`PPDP_IRQ_W-1:0] irq_stat;
  logic [`PPDP_IRQ_W-1:0] irq_en;
  logic [`PPDP_IRQ_W-1:0] irq_ev;
  logic [`PPDP_IRQ_W-1:0] next_irq_stat;
  logic [7:0] rx_byte;
  logic byte_ready;
  logic init_done;
  logic init_seen;
  logic ack_done;
  logic [31:0] rd_data;
  logic rd_err;
  logic wr_err;
  logic [31:0] status_word;
  logic wr_ctrl;
  logic wr_irq_en;
  logic wr_irq_clr;
  logic rd_pop;
  logic online;
  logic paper_gone;
  logic fault;
  logic printing;
  logic host_selected;
  logic auto_feed_req;
  logic init_active;
  logic can_accept;
  logic capture;
  logic ctrl_reset;

  // ***********************************************
  // bus slave
  // ***********************************************
  ppdp_axil_slave u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .req(req),
    .rd_data(rd_data),
    .rd_err(rd_err),
    .wr_err(wr_err)
  );

  // ***********************************************
  // printer conditions
  // ***********************************************
  // control fields and effective host levels
  assign online = ctrl[`PPDP_CTRL_ONLINE];
  assign paper_gone = ctrl[`PPDP_CTRL_PAPER_OUT];
  assign fault = ctrl[`PPDP_CTRL_FAULT];
  assign printing = ctrl[`PPDP_CTRL_PRINTING];
  assign host_selected = !host_in.host_select_n ||
    ctrl[`PPDP_CTRL_SEL_FORCE];
  assign auto_feed_req = !host_in.auto_line_feed_n ||
    ctrl[`PPDP_CTRL_ALF_FORCE];
  assign init_active = !host_in.init_n;
  assign ctrl_reset = !aresetn || init_done;

  // the port may take a byte only in this condition
  assign can_accept = online && !paper_gone && !fault && !printing &&
    host_selected && !init_active;

  // ***********************************************
  // initialise filter
  // ***********************************************
  // initialise must stay low for the full count before it acts
  ppdp_timer #(
    .W(`PPDP_TMR_W),
    .LIMIT(INIT_LIM)
  ) u_init_tmr (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(host_in.init_n),
    .run(init_active),
    .done(init_done)
  );

  // remember that the long pulse was already reported
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      init_seen <= 1'b0;
    end else begin
      init_seen <= init_done;
    end
  end

  // ***********************************************
  // acknowledge pulse timer
  // ***********************************************
  ppdp_timer #(
    .W(`PPDP_TMR_W),
    .LIMIT(ACK_LIM)
  ) u_ack_tmr (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(state != ppdp_pkg::PPDP_ACK),
    .run(1'b1),
    .done(ack_done)
  );

  // ***********************************************
  // handshake state machine
  // ***********************************************
  // a low strobe starts a capture when the port can accept
  assign capture = !host_in.strobe_n && can_accept &&
    (state == ppdp_pkg::PPDP_IDLE ||
     state == ppdp_pkg::PPDP_ACK);

  // next state
  always_comb begin
    next_state = state;
    case (state)
      ppdp_pkg::PPDP_IDLE: begin
        if (capture) begin
          next_state = ppdp_pkg::PPDP_TAKE;
        end
      end
      ppdp_pkg::PPDP_TAKE: begin
        if (host_in.strobe_n) begin
          next_state = ppdp_pkg::PPDP_HOLD; // strobe back to idle
        end
      end
      ppdp_pkg::PPDP_HOLD: begin
        if (!byte_ready && can_accept) begin
          next_state = ppdp_pkg::PPDP_ACK;
        end
      end
      ppdp_pkg::PPDP_ACK: begin
        if (capture) begin
          next_state = ppdp_pkg::PPDP_TAKE;
        end else if (ack_done) begin
          next_state = ppdp_pkg::PPDP_IDLE;
        end
      end
      default: begin
        next_state = ppdp_pkg::PPDP_IDLE;
      end
    endcase
  end

  // state register; a long initialise returns to idle
  always_ff @(posedge aclk) begin
    if (ctrl_reset) begin
      state <= ppdp_pkg::PPDP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // received byte, bit one of the host in bit 0
  always_ff @(posedge aclk) begin
    if (ctrl_reset) begin
      rx_byte <= 8'h0;
    end else if (capture) begin
      rx_byte <= host_in.data;
    end
  end

  // byte held for firmware until it reads the data register
  always_ff @(posedge aclk) begin
    if (ctrl_reset) begin
      byte_ready <= 1'b0;
    end else if (capture) begin
      byte_ready <= 1'b1;
    end else if (rd_pop) begin
      byte_ready <= 1'b0;
    end
  end

  // ***********************************************
  // host outputs
  // ***********************************************
  // busy from the start of a strobe until the acknowledge, and whenever
  // the printer cannot take data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_out <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    end else begin
      host_out.byte_accepted_pulse_n <=
        (next_state != ppdp_pkg::PPDP_ACK);
      host_out.busy <= (next_state == ppdp_pkg::PPDP_TAKE) ||
        (next_state == ppdp_pkg::PPDP_HOLD) || !can_accept;
      host_out.paper_out <= paper_gone;
      host_out.printer_selected <= online;
      host_out.error_n <= online && !paper_gone && !fault;
    end
  end

  // ***********************************************
  // register decode
  // ***********************************************
  assign wr_ctrl = req.wr && req.waddr == `PPDP_CTRL_OFS && req.wstrb[0];
  assign wr_irq_en = req.wr && req.waddr == `PPDP_IRQ_EN_OFS &&
    req.wstrb[0];
  assign wr_irq_clr = req.wr && req.waddr == `PPDP_IRQ_CLR_OFS &&
    req.wstrb[0];
  assign rd_pop = req.rd && req.raddr == `PPDP_DATA_OFS;
  assign wr_err = !(req.waddr == `PPDP_CTRL_OFS ||
    req.waddr == `PPDP_IRQ_EN_OFS || req.waddr == `PPDP_IRQ_CLR_OFS);
  assign rd_err = !(req.raddr == `PPDP_CTRL_OFS ||
    req.raddr == `PPDP_STATUS_OFS || req.raddr == `PPDP_DATA_OFS ||
    req.raddr == `PPDP_IRQ_STAT_OFS || req.raddr == `PPDP_IRQ_EN_OFS ||
    req.raddr == `PPDP_IRQ_CLR_OFS);
  assign status_word = {26'h0, init_active, !host_in.strobe_n,
    host_selected, auto_feed_req, host_out.busy, byte_ready};

  // read data selection; clear register and holes read zero
  assign rd_data =
    (req.raddr == `PPDP_CTRL_OFS) ? {26'h0, ctrl} :
    (req.raddr == `PPDP_STATUS_OFS) ? status_word :
    (req.raddr == `PPDP_DATA_OFS) ? {24'h0, rx_byte} :
    (req.raddr == `PPDP_IRQ_STAT_OFS) ? {30'h0, irq_stat} :
    (req.raddr == `PPDP_IRQ_EN_OFS) ? {30'h0, irq_en} : 32'h0;

  // ***********************************************
  // control and enable registers
  // ***********************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `PPDP_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= req.wdata[`PPDP_CTRL_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en <= '0;
    end else if (wr_irq_en) begin
      irq_en <= req.wdata[`PPDP_IRQ_W-1:0];
    end
  end

  // ***********************************************
  // interrupt
  // ***********************************************
  // events: byte captured, long initialise recognised; set beats clear
  assign irq_ev[`PPDP_IRQ_BYTE] = capture;
  assign irq_ev[`PPDP_IRQ_INIT] = init_done && !init_seen;
  assign next_irq_stat = (irq_stat &
    ~(wr_irq_clr ? req.wdata[`PPDP_IRQ_W-1:0] : '0)) | irq_ev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= next_irq_stat;
    end
  end

  assign irq = |(irq_stat & irq_en);

endmodule

// ==== tb/ppdp_port_chk.sv ====
// assertions on the print data port pins and bus answers
`timescale 1ns/1ps
module ppdp_port_chk (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, low
  input wire logic s_axi_awvalid, // write address valid
  input wire logic s_axi_awready, // write address ready
  input wire logic s_axi_wvalid, // write data valid
  input wire logic s_axi_bvalid, // write response valid
  input wire logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic s_axi_rvalid, // read data valid
  input wire ppdp_pkg::ppdp_host_in_t host_in, // host pins in
  input wire ppdp_pkg::ppdp_host_out_t host_out // host pins out
);
  // ****************
  // helpers
  // ****************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic [7:0] ack_cnt;

  // counts the cycles of a low acknowledge
  always_ff @(posedge aclk) begin
    if (!aresetn || host_out.byte_accepted_pulse_n)
      ack_cnt <= 8'h00;
    else
      ack_cnt <= ack_cnt + 8'h01;
  end

  // strobe seen while the port says it can take a byte
  sequence s_take;
    !host_out.busy && !host_in.strobe_n && host_in.init_n;
  endsequence
  sequence s_ack_start;
    $fell(host_out.byte_accepted_pulse_n);
  endsequence

  // ****************
  // assertions
  // ****************
  a_busy_at_take:
    assert property (s_take |=> host_out.busy)
    else $error("busy did not rise on strobe");
  a_ack_after_hold:
    assert property (s_ack_start |-> $past(host_in.strobe_n))
    else $error("acknowledge while strobe low");
  a_ack_not_busy:
    assert property (!host_out.byte_accepted_pulse_n |-> !host_out.busy)
    else $error("busy high during acknowledge");
  a_ack_max_len:
    assert property (ack_cnt <= 8'h64)
    else $error("acknowledge too long");
  a_ack_full_len:
    assert property ($rose(host_out.byte_accepted_pulse_n)
      && !host_out.busy |-> ack_cnt == 8'h64)
    else $error("acknowledge too short");
  a_paper_busy:
    assert property (host_out.paper_out |-> host_out.busy
      && !host_out.error_n)
    else $error("paper out but not busy");
  a_unsel_busy:
    assert property (!host_out.printer_selected |-> host_out.busy
      && !host_out.error_n)
    else $error("deselected but not busy");
  a_wr_answer:
    assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready
      |=> s_axi_bvalid)
    else $error("write answer late");
  a_rd_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule

// ==== tb/ppdp_host_model.sv ====
// host computer model driving the parallel print pins
`timescale 1ns/1ps
module ppdp_host_model (
  input wire logic aclk, // system clock
  input wire ppdp_pkg::ppdp_host_out_t host_out, // pins from port
  output ppdp_pkg::ppdp_host_in_t host_in // pins to port
);
  // ****************
  // pin drivers
  // ****************
  // idle levels: strobe and init high, data at a neutral value
  initial host_in = '{1'b1, 8'h00, 1'b1, 1'b1, 1'b1};

  // one byte: wait for the port, strobe low, release
  task automatic send_byte(input logic [7:0] b, input int len,
    input logic rude);
    int n;
    for (n = 0; n < 3000 && !rude && host_out.busy; n++)
      @(negedge aclk);
    @(posedge aclk);
    host_in.data <= b;
    host_in.strobe_n <= 1'b0;
    repeat (len < 11 ? 11 : len) @(posedge aclk);
    host_in.strobe_n <= 1'b1;
    host_in.data <= ~b; // released lines show no stale byte
    for (n = 0; n < 3000 && !rude; n++) begin
      @(negedge aclk);
      if (!host_out.byte_accepted_pulse_n)
        break;
    end
  endtask

  // level pins: auto feed and host select
  task automatic set_pins(input logic alf_n, input logic sel_n);
    @(posedge aclk);
    host_in.auto_line_feed_n <= alf_n;
    host_in.host_select_n <= sel_n;
  endtask

  // initialise pulse of n cycles; over 1000 resets the handshake and drops the held byte
  task automatic pulse_init(input int n);
    @(posedge aclk);
    host_in.init_n <= 1'b0;
    repeat (n) @(posedge aclk);
    host_in.init_n <= 1'b1;
  endtask
endmodule

// ==== tb/parallel_print_data_port_tb.sv ====
// self-checking bench for the parallel print data port
`timescale 1ns/1ps
module parallel_print_data_port_tb;
  logic aclk, aresetn, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr, b;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  ppdp_pkg::ppdp_host_in_t host_in;
  ppdp_pkg::ppdp_host_out_t host_out;
  int num_errors, compares, seed, i, len;
  logic [5:0] c;
  logic [5:0] ctab [6] = '{6'h10, 6'h11, 6'h13, 6'h15, 6'h19, 6'h01};
  logic [7:0] btab [4] = '{8'h00, 8'hff, 8'h01, 8'h80};

  ppdp_port u_ppdp_port (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .host_in, .host_out,
    .irq);
  ppdp_host_model u_ppdp_host_model (.aclk, .host_out, .host_in);

  // ****************
  // clock and helpers
  // ****************
  initial aclk = 1'b0;
  always #25 aclk = ~aclk;

  function automatic logic exp_busy(input logic [5:0] k, input logic s);
    return !k[0] | k[1] | k[2] | k[3] | (s & !k[4]);
  endfunction
  function automatic logic exp_on(input logic n, input logic f);
    return !n | f;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkb(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask

  // bus write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
    input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(negedge aclk); while (!s_axi_awready);
    @(posedge aclk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_bvalid);
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  // bus read
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
    output logic [1:0] rr);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    rr = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
    input logic [31:0] m, input logic [31:0] e);
    rd(a, d, r);
    chk(nm, e, d & m);
    chk("rresp", 32'h0, {30'h0, r});
  endtask

  // firmware side of one byte: interrupt, then fetch the byte
  task automatic fw_take(input logic [7:0] e);
    int n;
    for (n = 0; n < 100 && irq !== 1'b1; n++)
      @(negedge aclk);
    chkb("irq", 1'b1, irq);
    while (!host_in.strobe_n) @(negedge aclk);
    chkb("busy", 1'b1, host_out.busy);
    rdc("status", 8'h04, 32'h3, 32'h3);
    rdc("data", 8'h08, 32'hff, {24'h0, e});
  endtask

  task automatic finish_test;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    finish_test;
  end

  // ****************
  // tests
  // ****************
  initial begin
    seed = 37860;
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chkb("busy", 1'b1, host_out.busy);
    chkb("ack_n", 1'b1, host_out.byte_accepted_pulse_n);
    rdc("ctrl", 8'h00, 32'h3f, 32'h10);
    rdc("irq_en", 8'h10, 32'h3, 32'h0);
    rdc("irq_stat", 8'h0c, 32'h3, 32'h0);
    rdc("irq_clr", 8'h14, 32'hffffffff, 32'h0);
    rd(8'h18, d, r);
    chk("rresp", 32'h2, {30'h0, r});
    wr(8'h1c, 32'h1, 2'h2);
    s_axi_wstrb <= 4'he;
    wr(8'h00, 32'h3f, 2'h0);
    s_axi_wstrb <= 4'hf;
    rdc("ctrl", 8'h00, 32'h3f, 32'h10);
    $display("test reset done");
    for (i = 0; i < 6; i++) begin
      c = ctab[i];
      wr(8'h00, {26'h0, c}, 2'h0);
      @(negedge aclk);
      chkb("busy", exp_busy(c, 1'b1), host_out.busy);
      chkb("paper_out", c[1], host_out.paper_out);
      chkb("selected", c[0], host_out.printer_selected);
      chkb("error_n", c[0] & !c[1] & !c[2], host_out.error_n);
      rdc("ctrl", 8'h00, 32'h3f, {26'h0, c});
    end
    $display("test pins done");
    wr(8'h14, 32'h3, 2'h0);
    u_ppdp_host_model.send_byte(8'h5a, 12, 1'b1);
    rdc("irq_stat", 8'h0c, 32'h1, 32'h0);
    wr(8'h00, 32'h13, 2'h0);
    u_ppdp_host_model.send_byte(8'ha5, 12, 1'b1);
    rdc("irq_stat", 8'h0c, 32'h1, 32'h0);
    for (i = 0; i < 4; i++) begin
      u_ppdp_host_model.set_pins(i[0], i[0]);
      wr(8'h00, {26'h0, i[1], i[1], 4'h1}, 2'h0);
      b = {4'h0, exp_on(i[0], i[1]), exp_on(i[0], i[1]), 2'h0};
      rdc("status", 8'h04, 32'hc, {24'h0, b});
    end
    $display("test refuse done");
    u_ppdp_host_model.set_pins(1'b1, 1'b0);
    wr(8'h00, 32'h1, 2'h0);
    wr(8'h10, 32'h1, 2'h0);
    for (i = 0; i < 8; i++) begin
      b = (i < 4) ? btab[i] : 8'($random(seed));
      len = 11 + ($random(seed) & 7);
      fork
        u_ppdp_host_model.send_byte(b, len, 1'b0);
        fw_take(b);
      join
      chkb("ack_n", 1'b0, host_out.byte_accepted_pulse_n);
      wr(8'h14, 32'h1, 2'h0);
      chkb("irq", 1'b0, irq);
      if (i[0])
        repeat (110) @(posedge aclk);
    end
    $display("test bytes done");
    wr(8'h10, 32'h2, 2'h0);
    u_ppdp_host_model.send_byte(8'h3c, 11, 1'b1);
    u_ppdp_host_model.pulse_init(30);
    rdc("status", 8'h04, 32'h1, 32'h1);
    rdc("irq_stat", 8'h0c, 32'h3, 32'h1);
    chkb("irq", 1'b0, irq);
    u_ppdp_host_model.pulse_init(1005);
    rdc("status", 8'h04, 32'h1, 32'h0);
    rdc("irq_stat", 8'h0c, 32'h3, 32'h3);
    chkb("irq", 1'b1, irq);
    wr(8'h14, 32'h3, 2'h0);
    rdc("irq_stat", 8'h0c, 32'h3, 32'h0);
    chkb("irq", 1'b0, irq);
    $display("test init done");
    finish_test;
  end
endmodule

bind ppdp_port ppdp_port_chk u_ppdp_port_chk (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .host_in, .host_out);
